// [asrc_cfg.svh]
// Summary of operation
// - write: select and strobe low, lanes gated
// - read: select, output enable low, strobe high
// - first rising control ends the write
// - data setup and hold against ending edge
`ifndef ASRC_CFG_SVH
`define ASRC_CFG_SVH
`define ASRC_ADDR_W 15
`define ASRC_DATA_W 16
`define ASRC_CLK_PERIOD_NS 10
`define ASRC_ACCESS_NS 10
`define ASRC_ACCESS_CYC ((`ASRC_ACCESS_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_STROBE_CYC 1
`define ASRC_CNT_W 4
`endif

// [asrc_pkg.sv]
package asrc_pkg;
    typedef enum logic [2:0] {
        ASRC_IDLE,
        ASRC_RD_OE,
        ASRC_RD_WAIT,
        ASRC_WR_SETUP,
        ASRC_WR_STROBE,
        ASRC_WR_HOLD,
        ASRC_TURN
    } asrc_state_t;
endpackage

// [asrc_req_if.sv]
interface asrc_req_if;
    logic valid;
    logic ready;
    logic write;
    logic [14:0] addr;
    logic [15:0] wdata;
    logic [1:0] lanes;
    modport master (output valid, output write, output addr, output wdata, output lanes,
        input ready);
    modport slave (input valid, input write, input addr, input wdata, input lanes,
        output ready);
endinterface

// [asrc_sync.sv]
`include "asrc_cfg.svh"
module asrc_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`ASRC_DATA_W-1:0] din,
    output logic [`ASRC_DATA_W-1:0] dout
);
    logic [`ASRC_DATA_W-1:0] s1_q;
    logic [`ASRC_DATA_W-1:0] s2_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= 16'h0000;
            s2_q <= 16'h0000;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end
    assign dout = s2_q;
endmodule // asrc_sync

// [asrc_ctrl.sv]
`include "asrc_cfg.svh"
module asrc_ctrl (
    input wire logic REF_CLK,
    input wire logic RESETN,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic [14:0] REQ_ADDR,
    input wire logic [15:0] REQ_WDATA,
    input wire logic [1:0] REQ_LANES,
    output logic RD_VALID,
    output logic [15:0] RD_DATA,
    output logic [14:0] MEM_ADDR,
    output logic CHIP_SELECT_N,
    output logic WRITE_STROBE_N,
    output logic OUTPUT_ENABLE_N,
    output logic LOW_LANE_SELECT_N,
    output logic HIGH_LANE_SELECT_N,
    input wire logic [15:0] DATA_I,
    output logic [15:0] DATA_O,
    output logic DATA_OE
);
    asrc_req_if req ();
    assign req.valid = REQ_VALID;
    assign req.write = REQ_WRITE;
    assign req.addr = REQ_ADDR;
    assign req.wdata = REQ_WDATA;
    assign req.lanes = REQ_LANES;
    assign REQ_READY = req.ready;

    asrc_pkg::asrc_state_t state_q;
    logic [`ASRC_CNT_W-1:0] cnt_q;
    logic [14:0] addr_q;
    logic [15:0] wdata_q;
    logic [1:0] lanes_q;
    logic cs_n_q, we_n_q, oe_n_q, ble_n_q, bhe_n_q, doe_q;
    logic [15:0] sync_data;
    logic rd_valid_q;
    logic [15:0] rd_data_q;
    logic wait_done;

    localparam logic [`ASRC_CNT_W-1:0] ACC_CYC = `ASRC_CNT_W'(`ASRC_ACCESS_CYC);
    localparam logic [`ASRC_CNT_W-1:0] STB_CYC = `ASRC_CNT_W'(`ASRC_STROBE_CYC);

    asrc_sync u_sync (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .din(DATA_I),
        .dout(sync_data)
    );

    // requests with no lane selected are still taken but touch nothing
    assign req.ready = (state_q == asrc_pkg::ASRC_IDLE);
    assign wait_done = (cnt_q == '0);

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            state_q <= asrc_pkg::ASRC_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                asrc_pkg::ASRC_IDLE: begin
                    if (req.valid) begin
                        // bus already released in idle, so reads start straight away
                        state_q <= req.write ? asrc_pkg::ASRC_WR_SETUP
                                             : asrc_pkg::ASRC_RD_OE;
                        cnt_q <= ACC_CYC;
                    end
                end
                asrc_pkg::ASRC_RD_OE: begin
                    state_q <= asrc_pkg::ASRC_RD_WAIT;
                    // two synchroniser stages plus access time
                    cnt_q <= ACC_CYC + `ASRC_CNT_W'(2);
                end
                asrc_pkg::ASRC_RD_WAIT: begin
                    if (wait_done) begin
                        state_q <= asrc_pkg::ASRC_TURN;
                    end else begin
                        cnt_q <= cnt_q - `ASRC_CNT_W'(1);
                    end
                end
                asrc_pkg::ASRC_WR_SETUP: begin
                    state_q <= asrc_pkg::ASRC_WR_STROBE;
                    cnt_q <= STB_CYC;
                end
                asrc_pkg::ASRC_WR_STROBE: begin
                    if (wait_done) begin
                        state_q <= asrc_pkg::ASRC_WR_HOLD;
                    end else begin
                        cnt_q <= cnt_q - `ASRC_CNT_W'(1);
                    end
                end
                asrc_pkg::ASRC_WR_HOLD: state_q <= asrc_pkg::ASRC_TURN;
                asrc_pkg::ASRC_TURN: state_q <= asrc_pkg::ASRC_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            addr_q <= 15'h0000;
            wdata_q <= 16'h0000;
            lanes_q <= 2'h0;
        end else if (req.valid && req.ready) begin
            addr_q <= req.addr;
            wdata_q <= req.wdata;
            lanes_q <= req.lanes;
        end
    end

    // pin controls; chip select high in idle puts the memory in standby
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            cs_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            ble_n_q <= 1'b1;
            bhe_n_q <= 1'b1;
            doe_q <= 1'b0;
        end else begin
            unique case (state_q)
                asrc_pkg::ASRC_RD_OE, asrc_pkg::ASRC_RD_WAIT: begin
                    cs_n_q <= 1'b0;
                    we_n_q <= 1'b1;
                    oe_n_q <= 1'b0;
                    ble_n_q <= ~lanes_q[0];
                    bhe_n_q <= ~lanes_q[1];
                    doe_q <= 1'b0;
                end
                asrc_pkg::ASRC_WR_SETUP: begin
                    cs_n_q <= 1'b0;
                    we_n_q <= 1'b1;
                    oe_n_q <= 1'b1;
                    ble_n_q <= ~lanes_q[0];
                    bhe_n_q <= ~lanes_q[1];
                    doe_q <= 1'b1;
                end
                asrc_pkg::ASRC_WR_STROBE: begin
                    cs_n_q <= 1'b0;
                    // strobe alone opens and closes the write window
                    we_n_q <= wait_done;
                    oe_n_q <= 1'b1;
                    doe_q <= 1'b1;
                end
                asrc_pkg::ASRC_WR_HOLD: begin
                    // data held one cycle past the strobe rising edge
                    we_n_q <= 1'b1;
                    cs_n_q <= 1'b1;
                    ble_n_q <= 1'b1;
                    bhe_n_q <= 1'b1;
                    doe_q <= 1'b0;
                end
                default: begin
                    cs_n_q <= 1'b1;
                    we_n_q <= 1'b1;
                    oe_n_q <= 1'b1;
                    ble_n_q <= 1'b1;
                    bhe_n_q <= 1'b1;
                    doe_q <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 16'h0000;
        end else begin
            rd_valid_q <= (state_q == asrc_pkg::ASRC_RD_WAIT) && wait_done;
            if ((state_q == asrc_pkg::ASRC_RD_WAIT) && wait_done) begin
                rd_data_q <= {lanes_q[1] ? sync_data[15:8] : 8'h00,
                              lanes_q[0] ? sync_data[7:0] : 8'h00};
            end
        end
    end

    assign MEM_ADDR = addr_q;
    assign CHIP_SELECT_N = cs_n_q;
    assign WRITE_STROBE_N = we_n_q;
    assign OUTPUT_ENABLE_N = oe_n_q;
    assign LOW_LANE_SELECT_N = ble_n_q;
    assign HIGH_LANE_SELECT_N = bhe_n_q;
    assign DATA_O = wdata_q;
    assign DATA_OE = doe_q;
    assign RD_VALID = rd_valid_q;
    assign RD_DATA = rd_data_q;

    property p_no_contention;
        @(posedge REF_CLK) disable iff (!RESETN)
        !(DATA_OE && !OUTPUT_ENABLE_N);
    endproperty
    a_no_contention: assert property (p_no_contention)
        else $error("controller drives data while memory outputs enabled");

    property p_write_oe_high;
        @(posedge REF_CLK) disable iff (!RESETN)
        !WRITE_STROBE_N |-> OUTPUT_ENABLE_N && !CHIP_SELECT_N && DATA_OE;
    endproperty
    a_write_oe_high: assert property (p_write_oe_high)
        else $error("write strobe low without proper write setup");

    property p_read_strobe_high;
        @(posedge REF_CLK) disable iff (!RESETN)
        !OUTPUT_ENABLE_N |-> WRITE_STROBE_N && !CHIP_SELECT_N;
    endproperty
    a_read_strobe_high: assert property (p_read_strobe_high)
        else $error("read with write strobe low or chip deselected");

    property p_data_hold;
        @(posedge REF_CLK) disable iff (!RESETN)
        $rose(WRITE_STROBE_N) |-> DATA_OE && $stable(DATA_O) && $stable(MEM_ADDR);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("write data or address changed at write end");

    property p_idle_standby;
        @(posedge REF_CLK) disable iff (!RESETN)
        REQ_READY |-> CHIP_SELECT_N;
    endproperty
    a_idle_standby: assert property (p_idle_standby)
        else $error("chip selected while controller idle");

    property p_read_done;
        @(posedge REF_CLK) disable iff (!RESETN)
        (REQ_VALID && REQ_READY && !REQ_WRITE) |-> ##[3:8] RD_VALID;
    endproperty
    a_read_done: assert property (p_read_done)
        else $error("read answer missing");

    property p_strobe_width;
        @(posedge REF_CLK) disable iff (!RESETN)
        $fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*1] ##1 WRITE_STROBE_N;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("write strobe width wrong");

    property p_lane_match;
        @(posedge REF_CLK) disable iff (!RESETN)
        !CHIP_SELECT_N |-> (LOW_LANE_SELECT_N == ~lanes_q[0])
                           && (HIGH_LANE_SELECT_N == ~lanes_q[1]);
    endproperty
    a_lane_match: assert property (p_lane_match)
        else $error("lane selects differ from request");
endmodule // asrc_ctrl

// [asrc_sram_model.sv]
module asrc_sram_model (
    input wire logic [14:0] addr,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic low_lane_select_n,
    input wire logic high_lane_select_n,
    input wire logic [15:0] data_bus,
    output logic [15:0] data_out,
    output logic [1:0] lane_drive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:32767];
    logic writing;
    logic reading;
    logic standby;
    assign standby = chip_select_n;
    assign writing = !chip_select_n && !write_strobe_n;
    assign reading = !chip_select_n && !output_enable_n && write_strobe_n;
    // stores follow the bus for the whole overlap, so the last value before the end wins
    always @* begin
        if (writing && !low_lane_select_n) begin
            mem[addr][7:0] = data_bus[7:0];
        end
        if (writing && !high_lane_select_n) begin
            mem[addr][15:8] = data_bus[15:8];
        end
    end
    assign data_out = mem[addr];
    assign lane_drive[0] = reading && !low_lane_select_n;
    assign lane_drive[1] = reading && !high_lane_select_n;
endmodule // asrc_sram_model

// [tb_async_sram_32kx16_port.sv]
module tb_async_sram_32kx16_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, valid = 1'b0, wr = 1'b0;
    logic [14:0] addr = 15'h0000;
    logic [15:0] wdata = 16'h0000;
    logic [1:0] lanes = 2'h0;
    logic ready, rd_valid, cs_n, we_n, oe_n, lo_n, hi_n, data_oe;
    logic [15:0] rd_data, data_o, dev, bus, flt_q = 16'h5A3C;
    logic [14:0] mem_addr;
    logic [1:0] drv;
    logic [15:0] ref_mem [0:32767];
    logic [14:0] pool [8];
    int err_count = 0, checked = 0, seed = 41044;
    always #5 clk = ~clk;
    // released lanes show a changing pattern so a stale value never passes
    always @(posedge clk) flt_q <= flt_q * 16'h0005 + 16'h0001;
    assign bus = data_oe ? data_o : {drv[1] ? dev[15:8] : flt_q[15:8],
        drv[0] ? dev[7:0] : flt_q[7:0]};
    asrc_ctrl u_asrc_ctrl (.REF_CLK(clk), .RESETN(resetn), .REQ_VALID(valid), .REQ_READY(ready),
        .REQ_WRITE(wr), .REQ_ADDR(addr), .REQ_WDATA(wdata), .REQ_LANES(lanes),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .MEM_ADDR(mem_addr), .CHIP_SELECT_N(cs_n),
        .WRITE_STROBE_N(we_n), .OUTPUT_ENABLE_N(oe_n), .LOW_LANE_SELECT_N(lo_n),
        .HIGH_LANE_SELECT_N(hi_n), .DATA_I(bus), .DATA_O(data_o), .DATA_OE(data_oe));
    asrc_sram_model u_asrc_sram_model (.addr(mem_addr), .chip_select_n(cs_n),
        .write_strobe_n(we_n), .output_enable_n(oe_n), .low_lane_select_n(lo_n),
        .high_lane_select_n(hi_n), .data_bus(bus), .data_out(dev), .lane_drive(drv));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [15:0] exp_rd(input logic [14:0] a, input logic [1:0] l);
        logic [15:0] v;
        v = ref_mem[a];
        return {l[1] ? v[15:8] : 8'h00, l[0] ? v[7:0] : 8'h00};
    endfunction
    task automatic req(input logic w, input logic [14:0] a, input logic [15:0] d,
            input logic [1:0] l);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (ready !== 1'b1 && n < 30);
        if (n >= 30) begin
            err_count++;
            complete_run();
        end
        @(posedge clk);
        valid <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        lanes <= l;
        @(posedge clk);
        valid <= 1'b0;
    endtask
    task automatic do_wr(input logic [14:0] a, input logic [15:0] d, input logic [1:0] l);
        logic [15:0] v;
        v = ref_mem[a];
        if (l[0]) v[7:0] = d[7:0];
        if (l[1]) v[15:8] = d[15:8];
        ref_mem[a] = v;
        req(1'b1, a, d, l);
    endtask
    task automatic do_rd(input logic [14:0] a, input logic [1:0] l);
        int n;
        req(1'b0, a, 16'h0000, l);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rd_valid !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_count++;
            complete_run();
        end
        check(rd_data, exp_rd(a, l));
    endtask
    // reset cut into a write before the strobe falls: pins back to standby, nothing stored
    task automatic mid_reset();
        req(1'b1, 15'h0000, 16'hFFFF, 2'h3);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check({11'h000, ready, cs_n, we_n, data_oe, rd_valid}, 16'h001C);
        do_rd(15'h0000, 2'h3);
    endtask
    // both parties on the bus at once
    always @(negedge clk) if (resetn && data_oe && drv != 2'h0) check(16'h0001, 16'h0000);
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        foreach (pool[i]) begin
            pool[i] = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7FFF : 15'($random(seed));
            do_wr(pool[i], 16'($random(seed)), 2'h3);
        end
        foreach (pool[i]) do_rd(pool[i], 2'h3);
        $display("test boundary done");
        for (int l = 0; l < 4; l++) begin
            do_wr(15'h7FFF, 16'($random(seed)), 2'(l));
            for (int r = 0; r < 4; r++) do_rd(15'h7FFF, 2'(r));
        end
        $display("test lanes done");
        repeat (40) begin
            if ($random(seed) & 1) do_wr(pool[$unsigned($random(seed)) % 8],
                16'($random(seed)), 2'($random(seed)));
            else do_rd(pool[$unsigned($random(seed)) % 8], 2'($random(seed)));
        end
        $display("test random done");
        mid_reset();
        $display("test reset done");
        complete_run();
    end
endmodule // tb_async_sram_32kx16_port
